// *** src/global_cfg_pkg.sv ***
package global_cfg_pkg;
    // ==========================================================
    // register indexes
    localparam logic [7:0] IDX_OSC = 8'h24;
    localparam logic [7:0] IDX_RSVD_A = 8'h25;
    localparam logic [7:0] IDX_ADDR_LO = 8'h26;
    localparam logic [7:0] IDX_ADDR_HI = 8'h27;
    localparam logic [7:0] IDX_RSVD_B = 8'h28;
    localparam logic [7:0] IDX_RSVD_C = 8'h29;
    localparam logic [7:0] IDX_TEST_F = 8'h2a;
    localparam logic [7:0] IDX_TEST_D = 8'h2b;
    localparam logic [7:0] IDX_TEST_KBC = 8'h2c;
    localparam logic [7:0] IDX_TEST_A = 8'h2d;
    localparam logic [7:0] IDX_TEST_B = 8'h2e;
    localparam logic [7:0] IDX_TEST_C = 8'h2f;
    localparam int TEST_COUNT = 6;
    // ==========================================================
    // reset values
    localparam logic [7:0] OSC_RESET = 8'h44;
    localparam logic [7:0] ADDR_LO_STRAP0 = 8'h2e;
    localparam logic [7:0] ADDR_LO_STRAP1 = 8'h4e;
    localparam logic [7:0] ADDR_HI_RESET = 8'h00;
    localparam logic [7:0] TEST_RESET = 8'h00;
    localparam logic [7:0] INDEX_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // ==========================================================
    // field layout
    localparam int OSC_PLL_BIT = 1;
    localparam int OSC_FIELD_LO = 2;
    localparam int OSC_FIELD_HI = 3;
    localparam int OSC_QUAL16_BIT = 6;
    localparam logic [1:0] OSC_OFF_CODE = 2'h3;
    localparam logic [7:0] OSC_WMASK = 8'h4e;
    localparam logic [7:0] OSC_RSVD54_MASK = 8'h30;
    localparam logic [7:0] OSC_QUAL16_MASK = 8'h40;
    localparam logic [7:0] ADDR_LO_WMASK = 8'hfe;
    localparam int KBC_RESET_BIT = 6;
    localparam logic [7:0] KBC_WMASK = 8'h40;
    localparam logic [15:0] DATA_PORT_BIT = 16'h0001;
    // ==========================================================
    // host command registers
    localparam logic [2:0] HREG_CTRL = 3'h0;
    localparam logic [2:0] HREG_INDEX = 3'h1;
    localparam logic [2:0] HREG_WDATA = 3'h2;
    localparam logic [2:0] HREG_CMD = 3'h3;
    localparam logic [2:0] HREG_RESULT = 3'h4;
    localparam logic [2:0] HREG_STATUS = 3'h5;
    localparam logic [2:0] HREG_BASE_LO = 3'h6;
    localparam logic [2:0] HREG_BASE_HI = 3'h7;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_REFUSED_BIT = 1;
    localparam int STAT_NOACK_BIT = 2;
    localparam logic [7:0] NOACK_DATA = 8'hff;
endpackage : global_cfg_pkg

// *** src/cfg_link.sv ***
`timescale 1ns/1ns
// ==========================================================
// index/data port link between host end and device end
interface cfg_link;
    logic [15:0] io_addr;
    logic [7:0] io_wdata;
    logic io_wr;
    logic io_rd;
    logic cfg_mode;
    logic [7:0] io_rdata;
    logic io_ack;

    modport host (
        output io_addr,
        output io_wdata,
        output io_wr,
        output io_rd,
        output cfg_mode,
        input io_rdata,
        input io_ack
    );

    modport device (
        input io_addr,
        input io_wdata,
        input io_wr,
        input io_rd,
        input cfg_mode,
        output io_rdata,
        output io_ack
    );
endinterface : cfg_link

// *** src/global_config_regs_upper.sv ***
`timescale 1ns/1ns
// Summary of operation
// - oscillator register loads 0x44 on three resets
// - bit 1 one stops PLL
// - oscillator field 11 stops oscillator, baud clock
// - bit 6 selects 12 or 16 bit decode
// - software should set 16 bit qualification
// - software writes zero to bits 5:4
// - reserved indexes ignore writes, read zero
// - address low bits 7:1, bit 0 zero
// - address low default follows strap pin
// - address high byte, resets to zero
// - software picks only even port addresses
// - low first; high write moves port
// - port address reset only hard, VCC POR
// - test register bit 6 holds keyboard reset
// - software never writes the other factory test registers
// - software writes only bit 6 there
// - test registers clear on supply resets
// - index then data, configuration mode only
// - all eight index bits decoded
module global_config_regs_upper
    import global_cfg_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic vcc_por,
    input wire logic standby_supply_power_on_reset,
    input wire logic hard_reset,
    input wire logic soft_reset,
    input wire logic strap_option,
    cfg_link.device link,
    output logic pll_stop,
    output logic osc_stop,
    output logic baud_clock_generator_en,
    output logic addr_qual16,
    output logic kbd_mcu_reset,
    output logic [15:0] config_base
);

    // ==========================================================
    // port decode
    function automatic logic port_hit(input logic [15:0] a, input logic [15:0] port,
                                      input logic q16);
        if (q16) begin
            port_hit = (a == port);
        end else begin
            port_hit = (a[11:0] == port[11:0]);
        end
    endfunction : port_hit

    function automatic logic test_slot(input logic [7:0] idx);
        test_slot = (idx >= IDX_TEST_F) && (idx <= IDX_TEST_C);
    endfunction : test_slot

    logic strap_meta_r;
    logic strap_sync_r;
    logic [7:0] index_r;
    logic [7:0] osc_r;
    logic [7:0] osc_nxt;
    logic osc_stop_r;
    logic baud_en_r;
    logic [7:0] addr_lo_r;
    logic [7:0] addr_hi_r;
    logic [15:0] base_r;
    logic [7:0] test_r [TEST_COUNT];
    logic [7:0] rdata_r;
    logic ack_r;
    logic [7:0] rd_val;
    logic idx_hit;
    logic dat_hit;
    logic dat_wr;
    logic dat_rd;
    logic full_def;
    logic osc_def;
    logic test_def;
    logic any_reset;
    logic [2:0] test_sel;

    // ==========================================================
    // strap synchroniser
    always_ff @(posedge core_clk) begin
        strap_meta_r <= strap_option;
        strap_sync_r <= strap_meta_r;
    end

    // ==========================================================
    // reset sources
    assign full_def = !rst_n || vcc_por || hard_reset;
    assign osc_def = full_def || standby_supply_power_on_reset;
    assign test_def = !rst_n || vcc_por || standby_supply_power_on_reset;
    assign any_reset = full_def || standby_supply_power_on_reset || soft_reset;

    // ==========================================================
    // index and data port decode
    assign idx_hit = link.cfg_mode
        && port_hit(link.io_addr, base_r, osc_r[OSC_QUAL16_BIT]);
    assign dat_hit = link.cfg_mode
        && port_hit(link.io_addr, base_r | DATA_PORT_BIT, osc_r[OSC_QUAL16_BIT]);
    assign dat_wr = dat_hit && link.io_wr;
    assign dat_rd = dat_hit && link.io_rd;
    assign test_sel = 3'(index_r - IDX_TEST_F);

    always_ff @(posedge core_clk) begin
        if (any_reset) begin
            index_r <= INDEX_RESET;
        end else if (idx_hit && link.io_wr) begin
            index_r <= link.io_wdata;
        end
    end

    // ==========================================================
    // oscillator and PLL control
    always_comb begin
        osc_nxt = osc_r;
        if (dat_wr && index_r == IDX_OSC) begin
            osc_nxt = link.io_wdata & OSC_WMASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (osc_def) begin
            osc_r <= OSC_RESET;
            osc_stop_r <= (OSC_RESET[OSC_FIELD_HI:OSC_FIELD_LO] == OSC_OFF_CODE);
            baud_en_r <= (OSC_RESET[OSC_FIELD_HI:OSC_FIELD_LO] != OSC_OFF_CODE);
        end else begin
            osc_r <= osc_nxt;
            osc_stop_r <= (osc_nxt[OSC_FIELD_HI:OSC_FIELD_LO] == OSC_OFF_CODE);
            baud_en_r <= (osc_nxt[OSC_FIELD_HI:OSC_FIELD_LO] != OSC_OFF_CODE);
        end
    end

    // ==========================================================
    // configuration port address
    always_ff @(posedge core_clk) begin
        if (full_def) begin
            addr_lo_r <= strap_sync_r ? ADDR_LO_STRAP1 : ADDR_LO_STRAP0;
            addr_hi_r <= ADDR_HI_RESET;
            base_r <= {ADDR_HI_RESET, strap_sync_r ? ADDR_LO_STRAP1 : ADDR_LO_STRAP0};
        end else if (dat_wr && index_r == IDX_ADDR_LO) begin
            addr_lo_r <= link.io_wdata & ADDR_LO_WMASK;
        end else if (dat_wr && index_r == IDX_ADDR_HI) begin
            addr_hi_r <= link.io_wdata;
            base_r <= {link.io_wdata, addr_lo_r};
        end
    end

    // ==========================================================
    // factory test registers
    always_ff @(posedge core_clk) begin
        if (test_def) begin
            for (int i = 0; i < TEST_COUNT; i++) begin
                test_r[i] <= TEST_RESET;
            end
        end else if (dat_wr && test_slot(index_r)) begin
            test_r[test_sel] <= link.io_wdata;
        end
    end

    // ==========================================================
    // read mux
    always_comb begin
        case (index_r)
            IDX_OSC: rd_val = osc_r;
            IDX_ADDR_LO: rd_val = addr_lo_r;
            IDX_ADDR_HI: rd_val = addr_hi_r;
            IDX_RSVD_A, IDX_RSVD_B, IDX_RSVD_C: rd_val = READ_ZERO;
            default: begin
                if (test_slot(index_r)) begin
                    rd_val = test_r[test_sel];
                end else begin
                    rd_val = READ_ZERO;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdata_r <= READ_ZERO;
            ack_r <= 1'b0;
        end else if (dat_rd) begin
            rdata_r <= rd_val;
            ack_r <= 1'b1;
        end else begin
            rdata_r <= READ_ZERO;
            ack_r <= 1'b0;
        end
    end

    // ==========================================================
    // outputs
    assign link.io_rdata = rdata_r;
    assign link.io_ack = ack_r;
    assign pll_stop = osc_r[OSC_PLL_BIT];
    assign osc_stop = osc_stop_r;
    assign baud_clock_generator_en = baud_en_r;
    assign addr_qual16 = osc_r[OSC_QUAL16_BIT];
    assign kbd_mcu_reset = test_r[3'(IDX_TEST_KBC - IDX_TEST_F)][KBC_RESET_BIT];
    assign config_base = base_r;

endmodule : global_config_regs_upper

// *** src/config_port_host.sv ***
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
module config_port_host
    import global_cfg_pkg::*;
#(
    parameter logic [15:0] DEFAULT_BASE = 16'h002e
)
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [2:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    output logic [7:0] cmd_rdata,
    cfg_link.host link
);

    typedef enum logic [1:0] {HS_IDLE, HS_DATA, HS_TURN, HS_TAKE} host_state_t;

    // ==========================================================
    // write shaping
    function automatic logic [7:0] shape(input logic [7:0] idx, input logic [7:0] d);
        case (idx)
            IDX_OSC: shape = (d & ~OSC_RSVD54_MASK) | OSC_QUAL16_MASK;
            IDX_ADDR_LO: shape = d & ADDR_LO_WMASK;
            IDX_TEST_KBC: shape = d & KBC_WMASK;
            default: shape = d;
        endcase
    endfunction : shape

    function automatic logic forbidden(input logic [7:0] idx);
        forbidden = (idx == IDX_TEST_F) || (idx == IDX_TEST_D) || (idx == IDX_TEST_A)
            || (idx == IDX_TEST_B) || (idx == IDX_TEST_C);
    endfunction : forbidden

    host_state_t state_r;
    logic cfg_mode_r;
    logic [7:0] index_r;
    logic [7:0] wdata_r;
    logic [7:0] result_r;
    logic refused_r;
    logic noack_r;
    logic op_rd_r;
    logic [15:0] base_r;
    logic [7:0] pend_lo_r;
    logic [15:0] io_addr_r;
    logic [7:0] io_wdata_r;
    logic io_wr_r;
    logic io_rd_r;
    logic [7:0] rdata_r;
    logic start_wr;
    logic start_rd;
    logic busy;
    logic bad_req;

    assign busy = (state_r != HS_IDLE);
    assign start_wr = cmd_wr && cmd_addr == HREG_WDATA;
    assign start_rd = cmd_wr && cmd_addr == HREG_CMD && cmd_wdata[0];
    assign bad_req = (start_wr || start_rd)
        && (busy || (start_wr && forbidden(index_r)));

    // ==========================================================
    // command registers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cfg_mode_r <= 1'b0;
            index_r <= INDEX_RESET;
        end else if (cmd_wr && cmd_addr == HREG_CTRL) begin
            cfg_mode_r <= cmd_wdata[0];
        end else if (cmd_wr && cmd_addr == HREG_INDEX && !busy) begin
            index_r <= cmd_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            refused_r <= 1'b0;
        end else if (bad_req) begin
            refused_r <= 1'b1;
        end else if (cmd_wr && cmd_addr == HREG_STATUS && cmd_wdata[STAT_REFUSED_BIT]) begin
            refused_r <= 1'b0;
        end
    end

    // ==========================================================
    // link sequencer
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_r <= HS_IDLE;
            op_rd_r <= 1'b0;
            wdata_r <= READ_ZERO;
            io_addr_r <= DEFAULT_BASE;
            io_wdata_r <= READ_ZERO;
            io_wr_r <= 1'b0;
            io_rd_r <= 1'b0;
        end else begin
            case (state_r)
                HS_IDLE: begin
                    if ((start_wr || start_rd) && !bad_req) begin
                        op_rd_r <= start_rd;
                        wdata_r <= shape(index_r, cmd_wdata);
                        io_addr_r <= base_r;
                        io_wdata_r <= index_r;
                        io_wr_r <= 1'b1;
                        state_r <= HS_DATA;
                    end
                end
                HS_DATA: begin
                    io_addr_r <= base_r | DATA_PORT_BIT;
                    io_wdata_r <= wdata_r;
                    io_wr_r <= !op_rd_r;
                    io_rd_r <= op_rd_r;
                    state_r <= HS_TURN;
                end
                HS_TURN: begin
                    io_wr_r <= 1'b0;
                    io_rd_r <= 1'b0;
                    state_r <= op_rd_r ? HS_TAKE : HS_IDLE;
                end
                HS_TAKE: state_r <= HS_IDLE;
                default: state_r <= HS_IDLE;
            endcase
        end
    end

    // ==========================================================
    // port address tracking
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            base_r <= DEFAULT_BASE;
            pend_lo_r <= DEFAULT_BASE[7:0];
        end else if (cmd_wr && cmd_addr == HREG_BASE_LO && !busy) begin
            base_r[7:0] <= cmd_wdata & ADDR_LO_WMASK;
            pend_lo_r <= cmd_wdata & ADDR_LO_WMASK;
        end else if (cmd_wr && cmd_addr == HREG_BASE_HI && !busy) begin
            base_r[15:8] <= cmd_wdata;
        end else if (state_r == HS_TURN && !op_rd_r && index_r == IDX_ADDR_LO) begin
            pend_lo_r <= wdata_r;
        end else if (state_r == HS_TURN && !op_rd_r && index_r == IDX_ADDR_HI) begin
            base_r <= {wdata_r, pend_lo_r};
        end
    end

    // ==========================================================
    // read result and register read port
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            result_r <= READ_ZERO;
            noack_r <= 1'b0;
        end else if (state_r == HS_TAKE) begin
            result_r <= link.io_ack ? link.io_rdata : NOACK_DATA;
            noack_r <= !link.io_ack;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdata_r <= READ_ZERO;
        end else if (cmd_rd) begin
            case (cmd_addr)
                HREG_CTRL: rdata_r <= {7'h00, cfg_mode_r};
                HREG_INDEX: rdata_r <= index_r;
                HREG_WDATA: rdata_r <= wdata_r;
                HREG_RESULT: rdata_r <= result_r;
                HREG_STATUS: rdata_r <= {5'h00, noack_r, refused_r, busy};
                HREG_BASE_LO: rdata_r <= base_r[7:0];
                HREG_BASE_HI: rdata_r <= base_r[15:8];
                default: rdata_r <= READ_ZERO;
            endcase
        end else begin
            rdata_r <= READ_ZERO;
        end
    end

    assign cmd_rdata = rdata_r;
    assign link.io_addr = io_addr_r;
    assign link.io_wdata = io_wdata_r;
    assign link.io_wr = io_wr_r;
    assign link.io_rd = io_rd_r;
    assign link.cfg_mode = cfg_mode_r;

endmodule : config_port_host

// *** tb/cfg_link_asserts.sv ***
`timescale 1ns/1ns
module cfg_link_asserts (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [15:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic cfg_mode,
    input wire logic [7:0] io_rdata,
    input wire logic io_ack
);
    // ====================
    // index last written on the link
    logic [7:0] idx_r;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            idx_r <= 8'h00;
        end else if (io_wr && !io_addr[0] && cfg_mode) begin
            idx_r <= io_wdata;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ====================
    // link checks
    ack_cause_a: assert property (io_ack
        |-> $past(io_rd) && $past(cfg_mode) && $past(io_addr[0]))
        else $error("ack without data read");
    ack_once_a: assert property (io_ack |=> !io_ack)
        else $error("ack longer than one cycle");
    rdata_idle_a: assert property (!io_ack |-> io_rdata == 8'h00)
        else $error("read data outside ack");
    strobe_excl_a: assert property (!(io_wr && io_rd))
        else $error("both strobes high");
    rd_after_index_a: assert property (io_rd |-> $past(io_wr) && !$past(io_addr[0])
        && io_addr == ($past(io_addr) | 16'h0001))
        else $error("read not after index");
    wr_after_index_a: assert property (io_wr && io_addr[0]
        |-> $past(io_wr) && !$past(io_addr[0]))
        else $error("data write not after index");
    rsvd_zero_a: assert property (io_ack && (idx_r inside {8'h25, 8'h28, 8'h29}
        || idx_r < 8'h24 || idx_r > 8'h2f) |-> io_rdata == 8'h00)
        else $error("reserved read not zero");
    lo_bit0_a: assert property (io_ack && idx_r == 8'h26 |-> !io_rdata[0])
        else $error("address low bit 0 set");
endmodule : cfg_link_asserts

// *** tb/tb_global_config_regs_upper.sv ***
`timescale 1ns/1ns
module tb_global_config_regs_upper import global_cfg_pkg::*;;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic vcc_por = 1'b0;
    logic standby_supply_power_on_reset = 1'b0;
    logic hard_reset = 1'b0;
    logic soft_reset = 1'b0;
    logic strap_option = 1'b0;
    logic [2:0] cmd_addr = 3'h0;
    logic [7:0] cmd_wdata = 8'h00;
    logic cmd_wr = 1'b0;
    logic cmd_rd = 1'b0;
    logic [7:0] cmd_rdata;
    logic pll_stop, osc_stop, baud_clock_generator_en, addr_qual16, kbd_mcu_reset;
    logic [15:0] config_base;
    int num_errors = 0;
    int tests_run = 0;

    always #5 core_clk = ~core_clk;

    cfg_link u_cfg_link ();
    global_config_regs_upper u_global_config_regs_upper (
        .core_clk(core_clk), .rst_n(rst_n), .vcc_por(vcc_por),
        .standby_supply_power_on_reset(standby_supply_power_on_reset),
        .hard_reset(hard_reset), .soft_reset(soft_reset), .strap_option(strap_option),
        .link(u_cfg_link.device), .pll_stop(pll_stop), .osc_stop(osc_stop),
        .baud_clock_generator_en(baud_clock_generator_en), .addr_qual16(addr_qual16),
        .kbd_mcu_reset(kbd_mcu_reset), .config_base(config_base));
    config_port_host #(.DEFAULT_BASE(16'h002e)) u_config_port_host (
        .core_clk(core_clk), .rst_n(rst_n), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata), .link(u_cfg_link.host));
    cfg_link_asserts u_cfg_link_asserts (
        .core_clk(core_clk), .rst_n(rst_n), .io_addr(u_cfg_link.io_addr),
        .io_wdata(u_cfg_link.io_wdata), .io_wr(u_cfg_link.io_wr), .io_rd(u_cfg_link.io_rd),
        .cfg_mode(u_cfg_link.cfg_mode), .io_rdata(u_cfg_link.io_rdata),
        .io_ack(u_cfg_link.io_ack));

    // ====================
    // bus tasks
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic cmd_write(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_wr <= 1'b1;
        @(posedge core_clk);
        cmd_wr <= 1'b0;
    endtask : cmd_write
    task automatic cmd_read(input logic [2:0] a, output logic [7:0] d);
        @(posedge core_clk);
        cmd_addr <= a;
        cmd_rd <= 1'b1;
        @(posedge core_clk);
        cmd_rd <= 1'b0;
        #1;
        d = cmd_rdata;
    endtask : cmd_read
    task automatic wait_idle();
        logic [7:0] s;
        s = 8'h01;
        for (int i = 0; i < 20 && s[0] !== 1'b0; i++) cmd_read(HREG_STATUS, s);
        chk("busy", 16'h0, {15'h0, s[0]});
    endtask : wait_idle
    task automatic dev_write(input logic [7:0] idx, input logic [7:0] d);
        cmd_write(HREG_INDEX, idx);
        cmd_write(HREG_WDATA, d);
        wait_idle();
    endtask : dev_write
    task automatic dev_read(input logic [7:0] idx, output logic [7:0] d);
        cmd_write(HREG_INDEX, idx);
        cmd_write(HREG_CMD, 8'h01);
        wait_idle();
        cmd_read(HREG_RESULT, d);
    endtask : dev_read
    task automatic set_base(input logic [15:0] b);
        cmd_write(HREG_BASE_LO, b[7:0]);
        cmd_write(HREG_BASE_HI, b[15:8]);
    endtask : set_base
    task automatic pulse(input int k);
        @(posedge core_clk);
        case (k)
            0: vcc_por <= 1'b1;
            1: standby_supply_power_on_reset <= 1'b1;
            2: hard_reset <= 1'b1;
            default: soft_reset <= 1'b1;
        endcase
        @(posedge core_clk);
        {vcc_por, standby_supply_power_on_reset, hard_reset, soft_reset} <= 4'h0;
        @(posedge core_clk);
    endtask : pulse
    function automatic logic [15:0] outs();
        return {11'h0, pll_stop, osc_stop, baud_clock_generator_en, addr_qual16, kbd_mcu_reset};
    endfunction : outs

    // ====================
    // scenarios
    task automatic t_reset_values();
        logic [7:0] d;
        logic [15:0] e;
        for (int i = 0; i < 12; i++) begin
            dev_read(8'h24 + i[7:0], d);
            e = (i == 0) ? 16'h0044 : (i == 2) ? 16'h002e : 16'h0000;
            chk("reset value", e, {8'h0, d});
        end
        chk("config_base", 16'h002e, config_base);
        chk("outputs", 16'h0006, outs());
        $display("done: reset values");
    endtask : t_reset_values
    task automatic t_osc();
        logic [7:0] d;
        logic [15:0] e;
        for (int c = 0; c < 8; c++) begin
            dev_write(IDX_OSC, {4'h3, c[2:1], c[0], 1'b0});
            dev_read(IDX_OSC, d);
            chk("osc read", {8'h0, 4'h4, c[2:1], c[0], 1'b0}, {8'h0, d});
            e = {11'h0, c[0], c[2:1] == 2'h3, c[2:1] != 2'h3, 2'h2};
            chk("osc outs", e, outs());
        end
        dev_write(IDX_OSC, 8'h44);
        $display("done: oscillator");
    endtask : t_osc
    task automatic t_reserved();
        logic [7:0] d;
        logic [7:0] idx [4] = '{8'h25, 8'h28, 8'h29, 8'ha4};
        for (int i = 0; i < 4; i++) dev_write(idx[i], 8'hff);
        for (int i = 0; i < 4; i++) begin
            dev_read(idx[i], d);
            chk("reserved read", 16'h0, {8'h0, d});
        end
        dev_read(IDX_OSC, d);
        chk("osc kept", 16'h44, {8'h0, d});
        $display("done: reserved");
    endtask : t_reserved
    task automatic t_kbc();
        logic [7:0] d;
        dev_write(IDX_TEST_KBC, 8'hff);
        chk("kbd reset on", 16'h1, {15'h0, kbd_mcu_reset});
        dev_read(IDX_TEST_KBC, d);
        chk("kbc read", 16'h40, {8'h0, d});
        dev_write(IDX_TEST_KBC, 8'h00);
        chk("kbd reset off", 16'h0, {15'h0, kbd_mcu_reset});
        dev_write(IDX_TEST_F, 8'h5a);
        cmd_read(HREG_STATUS, d);
        chk("refused flag", 16'h1, {15'h0, d[1]});
        cmd_write(HREG_STATUS, 8'h02);
        cmd_read(HREG_STATUS, d);
        chk("refused cleared", 16'h0, {15'h0, d[1]});
        dev_read(IDX_TEST_F, d);
        chk("test reg kept", 16'h0, {8'h0, d});
        $display("done: keyboard reset");
    endtask : t_kbc
    task automatic t_mode();
        logic [7:0] d;
        cmd_write(HREG_CTRL, 8'h00);
        dev_write(IDX_TEST_KBC, 8'h40);
        chk("write outside mode", 16'h0, {15'h0, kbd_mcu_reset});
        dev_read(IDX_OSC, d);
        chk("read outside mode", 16'hff, {8'h0, d});
        cmd_read(HREG_STATUS, d);
        chk("no ack flag", 16'h1, {15'h0, d[2]});
        cmd_write(HREG_CTRL, 8'h01);
        set_base(16'h102e);
        dev_read(IDX_OSC, d);
        chk("upper address miss", 16'hff, {8'h0, d});
        set_base(16'h002e);
        $display("done: config mode");
    endtask : t_mode
    task automatic t_relocate();
        logic [7:0] d;
        dev_write(IDX_ADDR_LO, 8'h61);
        chk("base after low", 16'h002e, config_base);
        dev_write(IDX_ADDR_HI, 8'h12);
        chk("base after high", 16'h1260, config_base);
        dev_read(IDX_ADDR_LO, d);
        chk("address low", 16'h60, {8'h0, d});
        dev_write(IDX_TEST_KBC, 8'h40);
        dev_write(IDX_OSC, 8'h0e);
        pulse(3);
        chk("soft base", 16'h1260, config_base);
        chk("soft outs", 16'h001b, outs());
        dev_read(IDX_ADDR_HI, d);
        chk("soft high", 16'h12, {8'h0, d});
        pulse(1);
        chk("standby base", 16'h1260, config_base);
        chk("standby outs", 16'h0006, outs());
        dev_write(IDX_TEST_KBC, 8'h40);
        dev_write(IDX_OSC, 8'h0e);
        pulse(2);
        chk("hard base", 16'h002e, config_base);
        chk("hard outs", 16'h0007, outs());
        set_base(16'h002e);
        dev_read(IDX_ADDR_HI, d);
        chk("hard high", 16'h0, {8'h0, d});
        $display("done: relocation");
    endtask : t_relocate
    task automatic t_strap();
        logic [7:0] d;
        @(posedge core_clk);
        strap_option <= 1'b1;
        repeat (3) @(posedge core_clk);
        dev_write(IDX_OSC, 8'h0e);
        pulse(0);
        chk("strap base", 16'h004e, config_base);
        chk("por outs", 16'h0006, outs());
        set_base(16'h004e);
        dev_read(IDX_ADDR_LO, d);
        chk("strap low", 16'h4e, {8'h0, d});
        dev_read(IDX_OSC, d);
        chk("osc after por", 16'h44, {8'h0, d});
        $display("done: strap");
    endtask : t_strap

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        cmd_write(HREG_CTRL, 8'h01);
        t_reset_values();
        t_osc();
        t_reserved();
        t_kbc();
        t_mode();
        t_relocate();
        t_strap();
        final_report();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        final_report();
    end
endmodule : tb_global_config_regs_upper
